// ---- src/ubac_core.sv ----
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
module ubac_core (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [ubac_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [31:0]                wb_dat_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic                       wb_we_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       sleep_i,
  input  wire logic                       transmit_clock_pin_i,
  output logic                            transmit_clock_pin_o,
  output logic                            transmit_clock_pin_oe_o,
  input  wire logic                       receive_data_pin_i,
  output logic                            receive_data_pin_o,
  output logic                            receive_data_pin_oe_o
);
  import ubac_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic       ack;                       // bus answer
    logic [7:0] rdat;                      // read data
    logic       clock_source_select;
    logic       transmit_nine_bit_select;
    logic       transmit_enable;
    logic       sync_mode;
    logic       high_baud_select;
    logic       transmit_ninth_bit;
    logic       serial_port_enable;
    logic       receive_nine_bit_select;
    logic       single_receive_enable;
    logic       continuous_receive_enable;
    logic       framing_error_flag;
    logic       overrun_error_flag;
    logic       receive_ninth_bit;
    logic [7:0] baud_divisor;
    logic [7:0] bcnt;                      // baud timer
    logic       tick;                      // one-cycle generator pulse
    logic       dt_s1, dt_s2;              // data pin synchroniser
    logic       ck_s1, ck_s2, ck_d;        // clock pin synchroniser
    logic [7:0] thold;                     // transmit holding word
    logic       thv;                       // holding word valid
    logic [8:0] transmit_shift_register;                       // transmit shift register
    ubac_tx_e   txst;
    logic [5:0] tx_sub;                    // ticks within a bit
    logic [3:0] tx_bit;
    ubac_rx_e   rxst;
    logic [5:0] rx_sub;
    logic [3:0] rx_bit;
    logic [1:0] vote;                      // first two samples
    logic [8:0] rsr;                       // receive shift register
    logic       dlv;                       // word complete pulse
    logic       dlv_fe;                    // its stop bit was low
    logic [7:0] receive_buffer;
    logic       rbv;                       // buffer holds a word
    logic [1:0] ph;                        // master clock phase ticks
    logic       mck;                       // master clock level
    logic       ck_o, ck_oe, dt_o, dt_oe;  // pin drivers
  } ubac_state_s;

  ubac_state_s q, n;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // ticks per bit less one for the selected mode
  function automatic logic [5:0] last_sub(input logic s, input logic h);
    logic [6:0] o;
    o = s ? OVS_SYNC : (h ? OVS_HIGH : OVS_LOW);
    return 6'(o - 7'h01);
  endfunction

  // middle tick of a bit
  function automatic logic [5:0] mid_sub(input logic s, input logic h);
    logic [6:0] o;
    o = s ? OVS_SYNC : (h ? OVS_HIGH : OVS_LOW);
    return 6'(o >> 1);
  endfunction

  logic [7:0] idx;        // register index from byte address
  logic       req;        // new bus request this cycle
  logic       wr;         // write taken
  logic       rd;         // read taken
  logic [7:0] tx_rd;      // transmit control read view
  logic [7:0] rc_rd;      // receive control read view
  logic [5:0] tlast;      // ticks per bit less one
  logic [5:0] tmid;
  logic [3:0] txlast;     // last transmit data bit
  logic [3:0] rxlast;     // last receive data bit
  logic       rx_prio;    // sync receive holds off transmit
  logic       tx_load;    // holding word moves to shifter
  logic       srise;      // sync clock rising event
  logic       sfall;      // sync clock falling event
  logic       maj;        // majority of three samples
  logic       rb_full;    // buffer full after this cycle's read

  assign idx    = wb_adr_i[9:2];
  assign req    = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr     = req && wb_we_i && wb_sel_i[0];
  assign rd     = req && !wb_we_i;
  assign tlast  = last_sub(q.sync_mode, q.high_baud_select);
  assign tmid   = mid_sub(q.sync_mode, q.high_baud_select);
  assign txlast = q.transmit_nine_bit_select ? LAST_9 : LAST_8;
  assign rxlast = q.receive_nine_bit_select ? LAST_9 : LAST_8;
  // receive enables win over transmit in sync mode
  assign rx_prio = q.sync_mode && (q.continuous_receive_enable ||
                   q.single_receive_enable);
  assign tx_load = (q.txst == TX_IDLE) && q.thv && q.transmit_enable &&
                   q.serial_port_enable && !rx_prio;
  // master edges come from our own divider, slave from the pin
  assign srise = q.clock_source_select ?
                 (q.tick && q.ph[0] && !q.mck) : (q.ck_s2 && !q.ck_d);
  assign sfall = q.clock_source_select ?
                 (q.tick && q.ph[0] && q.mck) : (!q.ck_s2 && q.ck_d);
  assign maj = (q.vote[0] & q.vote[1]) | (q.vote[0] & q.dt_s2) |
               (q.vote[1] & q.dt_s2);
  assign rb_full = q.rbv && !(rd && idx == IDX_RCV_DATA);
  // reserved bit three is a constant zero
  assign tx_rd = {q.clock_source_select, q.transmit_nine_bit_select,
                  q.transmit_enable, q.sync_mode, 1'b0,
                  q.high_baud_select, q.txst == TX_IDLE,
                  q.transmit_ninth_bit};
  assign rc_rd = {q.serial_port_enable, q.receive_nine_bit_select,
                  q.single_receive_enable, q.continuous_receive_enable,
                  1'b0, q.framing_error_flag, q.overrun_error_flag,
                  q.receive_ninth_bit};

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = q;
    // classic wishbone: answer one cycle after request, drop next cycle
    n.ack  = req;
    n.rdat = 8'h00;
    if (rd) begin
      case (idx)
        IDX_XMT_CTL:  n.rdat = tx_rd;
        IDX_RCV_CTL:  n.rdat = rc_rd;
        IDX_DIVISOR:  n.rdat = q.baud_divisor;
        IDX_RCV_DATA: n.rdat = q.receive_buffer;
        default:      n.rdat = 8'h00; // unmapped reads zero
      endcase
    end
    n.rbv = rb_full; // reading the buffer frees it

    // synchronisers; only the second stage and the clock's ck_d are looked at
    n.dt_s1 = receive_data_pin_i;
    n.dt_s2 = q.dt_s1;
    n.ck_s1 = transmit_clock_pin_i;
    n.ck_s2 = q.ck_s1;
    n.ck_d  = q.ck_s2;

    // baud timer: counts N..0, so one tick every N+1 cycles
    n.bcnt = (q.bcnt == 8'h00) ? q.baud_divisor : 8'(q.bcnt - 8'h01);
    // async bit timing freezes in sleep because its ticks stop
    n.tick = (q.bcnt == 8'h00) && !(sleep_i && !q.sync_mode);

    n.dlv    = 1'b0;
    n.dlv_fe = 1'b0;

    // master clock: toggles every two ticks, four ticks a bit
    if (q.sync_mode && q.clock_source_select &&
        (q.txst != TX_IDLE || q.rxst != RX_IDLE)) begin
      if (q.tick) begin
        n.ph = 2'(q.ph + 2'h1);
        if (q.ph[0]) begin
          n.mck = !q.mck;
        end
      end
    end else begin
      n.ph  = 2'h0;
      n.mck = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // transmitter

    if (!q.transmit_enable || !q.serial_port_enable) begin
      n.txst = TX_IDLE; // clearing the enable aborts the word
      n.ck_o = 1'b1;
    end else if (tx_load) begin
      n.transmit_shift_register    = {q.transmit_ninth_bit, q.thold};
      n.thv    = 1'b0;
      n.tx_sub = 6'h00;
      n.tx_bit = 4'h0;
      if (q.sync_mode) begin
        n.txst = TX_DATA;
        n.dt_o = q.thold[0];
      end else begin
        n.txst = TX_START;
        n.ck_o = 1'b0;
      end
    end else if (q.sync_mode) begin
      // sync: next bit leaves on each falling clock edge
      if (q.txst == TX_DATA && sfall) begin
        if (q.tx_bit == txlast) begin
          n.txst = TX_IDLE;
        end else begin
          n.transmit_shift_register    = {1'b0, q.transmit_shift_register[8:1]};
          n.dt_o   = q.transmit_shift_register[1];
          n.tx_bit = 4'(q.tx_bit + 4'h1);
        end
      end
    end else if (q.tick && q.txst != TX_IDLE) begin
      n.tx_sub = 6'(q.tx_sub + 6'h01);
      if (q.tx_sub == tlast) begin
        n.tx_sub = 6'h00;
        case (q.txst)
          TX_START: begin
            n.txst = TX_DATA;
            n.ck_o = q.transmit_shift_register[0];
          end
          TX_DATA: begin
            // the ninth bit follows the eighth, then the stop bit
            if (q.tx_bit == txlast) begin
              n.txst = TX_STOP;
              n.ck_o = 1'b1;
            end else begin
              n.transmit_shift_register    = {1'b0, q.transmit_shift_register[8:1]};
              n.ck_o   = q.transmit_shift_register[1];
              n.tx_bit = 4'(q.tx_bit + 4'h1);
            end
          end
          TX_STOP: n.txst = TX_IDLE;
          default: n.txst = TX_IDLE;
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////
    // receiver

    if (!q.serial_port_enable) begin
      n.rxst = RX_IDLE;
    end else if (q.sync_mode) begin
      // sync: single receive only counts for a master
      if (q.rxst == RX_IDLE) begin
        if (q.continuous_receive_enable ||
            (q.single_receive_enable && q.clock_source_select)) begin
          n.rxst   = RX_DATA;
          n.rx_bit = 4'h0;
        end
      end else if (!rx_prio) begin
        n.rxst = RX_IDLE;
      end else if (srise) begin
        n.rsr    = {q.dt_s2, q.rsr[8:1]};
        n.rx_bit = 4'(q.rx_bit + 4'h1);
        if (q.rx_bit == rxlast) begin
          n.dlv  = 1'b1;
          n.rxst = RX_IDLE;
          // continuous receive keeps going and keeps the single bit
          if (!q.continuous_receive_enable) begin
            n.single_receive_enable = 1'b0;
          end
        end
      end
    end else if (!q.continuous_receive_enable) begin
      n.rxst = RX_IDLE;
    end else if (q.rxst == RX_IDLE) begin
      if (!q.dt_s2) begin
        n.rxst   = RX_START; // falling edge: possible start bit
        n.rx_sub = 6'h00;
      end
    end else if (q.tick) begin
      n.rx_sub = (q.rx_sub == tlast) ? 6'h00 : 6'(q.rx_sub + 6'h01);
      // three samples around the middle of the bit
      if (q.rx_sub == 6'(tmid - 6'h01)) begin
        n.vote[0] = q.dt_s2;
      end
      if (q.rx_sub == tmid) begin
        n.vote[1] = q.dt_s2;
      end
      if (q.rx_sub == 6'(tmid + 6'h01)) begin
        case (q.rxst)
          RX_START: begin
            // a high vote was a glitch; go back to hunting
            if (maj) begin
              n.rxst = RX_IDLE;
            end
          end
          RX_DATA: n.rsr = {maj, q.rsr[8:1]};
          RX_STOP: begin
            // decide at mid stop so the next start edge is seen
            n.dlv    = 1'b1;
            n.dlv_fe = !maj;
            n.rxst   = RX_IDLE;
          end
          default: n.rxst = RX_IDLE;
        endcase
      end
      if (q.rx_sub == tlast) begin
        case (q.rxst)
          RX_START: begin
            n.rxst   = RX_DATA;
            n.rx_bit = 4'h0;
          end
          RX_DATA: begin
            if (q.rx_bit == rxlast) begin
              n.rxst = RX_STOP;
            end else begin
              n.rx_bit = 4'(q.rx_bit + 4'h1);
            end
          end
          default: n.rxst = q.rxst;
        endcase
      end
    end

    // completed word goes to the buffer unless it is still full or an overrun is already flagged
    if (q.dlv && !q.overrun_error_flag) begin
      if (rb_full) begin
        n.overrun_error_flag = 1'b1; // word lost, receive stalls
      end else begin
        n.receive_buffer     = q.receive_nine_bit_select ?
                               q.rsr[7:0] : q.rsr[8:1];
        n.receive_ninth_bit  = q.rsr[8];
        n.framing_error_flag = q.dlv_fe;
        n.rbv                = 1'b1;
      end
    end
    if (!q.continuous_receive_enable) begin
      n.overrun_error_flag = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // pin drivers

    if (!q.serial_port_enable) begin
      n.ck_oe = 1'b0;
      n.dt_oe = 1'b0;
    end else if (q.sync_mode) begin
      n.ck_oe = q.clock_source_select;
      n.dt_oe = (q.txst != TX_IDLE);
    end else begin
      n.ck_oe = q.transmit_enable;
      n.dt_oe = 1'b0;
    end
    if (q.sync_mode && q.clock_source_select) begin
      n.ck_o = n.mck;
    end else if (q.sync_mode) begin
      n.ck_o = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////
    // register writes last, so software sets win this cycle

    if (wr) begin
      case (idx)
        IDX_XMT_CTL: begin
          n.clock_source_select      = wb_dat_i[B_CLOCK_SOURCE_SELECT];
          n.transmit_nine_bit_select = wb_dat_i[B_TX9];
          n.transmit_enable          = wb_dat_i[B_TRANSMIT_ENABLE];
          n.sync_mode                = wb_dat_i[B_SYNC];
          n.high_baud_select         = wb_dat_i[B_HIGH_BAUD_SELECT];
          n.transmit_ninth_bit       = wb_dat_i[B_TRANSMIT_NINTH_BIT];
        end
        IDX_RCV_CTL: begin
          n.serial_port_enable        = wb_dat_i[B_SERIAL_PORT_ENABLE];
          n.receive_nine_bit_select   = wb_dat_i[B_RX9];
          n.single_receive_enable     = wb_dat_i[B_SINGLE_RECEIVE_ENABLE];
          n.continuous_receive_enable = wb_dat_i[B_CONTINUOUS_RECEIVE_ENABLE];
        end
        IDX_DIVISOR: begin
          n.baud_divisor = wb_dat_i[7:0];
          n.bcnt         = wb_dat_i[7:0];
        end
        IDX_XMT_DATA: begin
          n.thold = wb_dat_i[7:0];
          n.thv   = 1'b1;
        end
        default: n.thv = n.thv; // unmapped writes are dropped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.txst <= TX_IDLE;
      q.rxst <= RX_IDLE;
      {q.clock_source_select, q.transmit_nine_bit_select,
       q.transmit_enable, q.sync_mode} <= XMT_CTL_RST[7:4];
      q.high_baud_select   <= XMT_CTL_RST[B_HIGH_BAUD_SELECT];
      q.transmit_ninth_bit <= XMT_CTL_RST[B_TRANSMIT_NINTH_BIT];
      {q.serial_port_enable, q.receive_nine_bit_select,
       q.single_receive_enable,
       q.continuous_receive_enable} <= RCV_CTL_RST[7:4];
      q.baud_divisor <= DIVISOR_RST;
      q.bcnt         <= DIVISOR_RST;
      q.ck_o         <= 1'b1;
      q.dt_s1        <= 1'b1;
      q.dt_s2        <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign wb_ack_o                = q.ack;
  assign wb_dat_o                = {24'h00_0000, q.rdat};
  assign transmit_clock_pin_o    = q.ck_o;
  assign transmit_clock_pin_oe_o = q.ck_oe;
  assign receive_data_pin_o      = q.dt_o;
  assign receive_data_pin_oe_o   = q.dt_oe;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_div_write;
    wr && idx == IDX_DIVISOR;
  endsequence

  property p_bit3_zero;
    !tx_rd[3] && !rc_rd[3];
  endproperty
  a_bit3_zero: assert property (p_bit3_zero)
    else $error("reserved bit three read nonzero");

  property p_transmit_shift_empty_busy;
    tx_load |=> !tx_rd[1];
  endproperty
  a_transmit_shift_empty_busy: assert property (p_transmit_shift_empty_busy)
    else $error("shift empty still set after load");

  property p_div_restart;
    s_div_write |=> q.bcnt == $past(wb_dat_i[7:0]);
  endproperty
  a_div_restart: assert property (p_div_restart)
    else $error("divisor write did not restart timer");

  property p_free_run;
    (q.bcnt == 8'h00 && !(wr && idx == IDX_DIVISOR))
      |=> q.bcnt == $past(q.baud_divisor);
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("baud timer did not reload");

  property p_start_bit;
    tx_load && !q.sync_mode && q.transmit_enable
      |=> !q.ck_o && q.txst == TX_START;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("async frame did not open with low start bit");

  property p_lsb_first;
    (q.txst == TX_START && q.tick && q.tx_sub == tlast &&
     q.transmit_enable && q.serial_port_enable)
      |=> q.ck_o == $past(q.transmit_shift_register[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("first data bit is not the lsb");

  property p_single_clear;
    (q.sync_mode && srise && q.rx_bit == rxlast && q.rxst == RX_DATA &&
     !q.continuous_receive_enable && !wr && q.serial_port_enable)
      |=> !q.single_receive_enable;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single receive not cleared after word");

  property p_overrun_error_flag_clear;
    !q.continuous_receive_enable |=> !q.overrun_error_flag;
  endproperty
  a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear)
    else $error("overrun kept with continuous receive off");

  property p_sleep_halt;
    sleep_i && !q.sync_mode |=> !q.tick;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt)
    else $error("async tick during sleep");

  property p_rx_prio;
    rx_prio |-> !tx_load;
  endproperty
  a_rx_prio: assert property (p_rx_prio)
    else $error("transmit started against receive enable");

  property p_port_off;
    !q.serial_port_enable |=> !q.ck_oe && !q.dt_oe;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("pin driven with port disabled");

endmodule

// ---- include/ubac_pkg.sv ----
package ubac_pkg;
  // bus geometry: byte address, one register per aligned word
  localparam int WB_AW = 10;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RCV_CTL  = 8'h18;
  localparam logic [7:0] IDX_XMT_DATA = 8'h19;
  localparam logic [7:0] IDX_RCV_DATA = 8'h1A;
  localparam logic [7:0] IDX_XMT_CTL  = 8'h98;
  localparam logic [7:0] IDX_DIVISOR  = 8'h99;
  // values after reset
  localparam logic [7:0] XMT_CTL_RST  = 8'h02;
  localparam logic [7:0] RCV_CTL_RST  = 8'h00;
  localparam logic [7:0] DIVISOR_RST  = 8'h00;
  // transmit control field positions
  localparam int B_CLOCK_SOURCE_SELECT = 7;
  localparam int B_TX9  = 6;
  localparam int B_TRANSMIT_ENABLE = 5;
  localparam int B_SYNC = 4;
  localparam int B_HIGH_BAUD_SELECT = 2;
  localparam int B_TRANSMIT_NINTH_BIT = 0;
  // receive control field positions
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_RX9  = 6;
  localparam int B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  // generator ticks per bit: async low, async high, sync
  localparam logic [6:0] OVS_LOW  = 7'h40;
  localparam logic [6:0] OVS_HIGH = 7'h10;
  localparam logic [6:0] OVS_SYNC = 7'h04;
  // last data bit index for 8- and 9-bit words
  localparam logic [3:0] LAST_8 = 4'h7;
  localparam logic [3:0] LAST_9 = 4'h8;
  // transmitter and receiver states
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } ubac_tx_e;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } ubac_rx_e;
endpackage

// ---- verif/ubac_term.sv ----
`timescale 1ns/100ps
// behavioural terminal at the far end of the two serial lines
module ubac_term (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  // line rests at mark level between frames
  initial line_o = 1'b1;
  //////////////////////////////////////////////////////////////////////////
  // one frame out: start, n data bits lsb first, stop
  task automatic send(input logic [8:0] d, input int n, input int bt);
    for (int i = -1; i <= n; i++) begin
      line_o <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
      repeat (bt) @(posedge clk_i);
    end
  endtask
  // one frame in; samples mid-bit, ok drops on missing start or stop
  task automatic recv(output logic [8:0] d, output bit ok, input int n,
                      input int bt);
    int k;
    d = '0;
    k = 0;
    while (line_i !== 1'b0 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    ok = (line_i === 1'b0);
    repeat (bt / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (bt) @(posedge clk_i);
      d[i] = line_i;
    end
    repeat (bt) @(posedge clk_i);
    if (line_i !== 1'b1) ok = 0;
  endtask
endmodule

// ---- verif/ubac_core_test.sv ----
`timescale 1ns/100ps
module ubac_core_test;
  import ubac_pkg::*;
  logic             clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic             tx_o, tx_oe, rx_line, tx_line;
  logic             sleep_i, dt_oe;
  logic [WB_AW-1:0] wb_adr_i;
  logic [31:0]      wb_dat_i, wb_dat_o, rd;
  logic [8:0]       got;
  bit               ok;
  int               miscompares, comparisons;
  // released transmit line floats to the pull-up
  assign tx_line = tx_oe ? tx_o : 1'b1;
  ubac_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .transmit_clock_pin_i(1'b1),
    .transmit_clock_pin_o(tx_o), .transmit_clock_pin_oe_o(tx_oe),
    .receive_data_pin_i(rx_line), .receive_data_pin_o(),
    .receive_data_pin_oe_o(dt_oe));
  ubac_term term (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
  //////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task give_verdict;
    $display("compares %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // classic single cycle; waits for ack under a bound
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= 32'(d);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      give_verdict;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    give_verdict;
  end
  // main sequence; divisor 0 and high baud give 16 cycles a bit
  initial begin
    rst_i = 1'b1;
    sleep_i = 1'b0;
    {wb_we_i, wb_cyc_i, wb_stb_i} = '0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, IDX_XMT_CTL, 0); chk("xmt ctl", 32'h02, rd);
    wb(0, IDX_RCV_CTL, 0); chk("rcv ctl", 32'h00, rd);
    wb(0, IDX_DIVISOR, 0); chk("divisor", 32'h00, rd);
    wb(0, 8'h00, 0); chk("unmapped", 32'h00, rd);
    $display("test reset values done");
    wb(1, IDX_DIVISOR, 8'h00);
    wb(1, IDX_RCV_CTL, 8'h90);
    wb(1, IDX_XMT_CTL, 8'h2C);
    wb(0, IDX_XMT_CTL, 0); chk("ctl bit3", 32'h26, rd);
    // eight- then nine-bit frames, ninth bit from control
    for (int j = 0; j < 2; j++) begin
      wb(1, IDX_XMT_CTL, j ? 8'h65 : 8'h24);
      fork
        term.recv(got, ok, 8 + j, 16);
        begin
          wb(1, IDX_XMT_DATA, 8'hA5);
          wb(0, IDX_XMT_CTL, 0); chk("busy", 32'h0, rd & 32'h2);
        end
      join
      chk("frame ok", 32'h1, 32'(ok));
      chk("tx word", j ? 32'h1A5 : 32'h0A5, 32'(got));
      repeat (20) @(posedge clk_i);
      wb(0, IDX_XMT_CTL, 0); chk("idle", 32'h2, rd & 32'h2);
    end
    $display("test transmit done");
    term.send(9'h03C, 8, 16);
    repeat (5) @(posedge clk_i);
    wb(0, IDX_RCV_DATA, 0); chk("rx word", 32'h3C, rd);
    term.send(9'h011, 8, 16);
    term.send(9'h022, 8, 16);
    repeat (5) @(posedge clk_i);
    wb(0, IDX_RCV_CTL, 0); chk("overrun", 32'h92, rd);
    wb(1, IDX_RCV_CTL, 8'h80);
    wb(0, IDX_RCV_CTL, 0); chk("ovr clr", 32'h80, rd);
    $display("test receive done");
    // sleep freezes an async frame on its start bit
    sleep_i <= 1'b1;
    wb(1, IDX_XMT_DATA, 8'h5A);
    repeat (100) @(posedge clk_i);
    chk("sleep line", 32'h0, 32'(tx_line));
    wb(0, IDX_XMT_CTL, 0); chk("sleep busy", 32'h0, rd & 32'h2);
    sleep_i <= 1'b0;
    repeat (250) @(posedge clk_i);
    wb(0, IDX_XMT_CTL, 0); chk("wake idle", 32'h2, rd & 32'h2);
    chk("data oe", 32'h0, 32'(dt_oe));
    $display("test sleep done");
    give_verdict;
  end
endmodule
